/* File: hw/corr_header_pkg.sv */
// Package for the correlation header framer: header layout constants and carrier structs.
// Assumes a byte-wide streaming datapath on a single clock.
package corr_header_pkg;

  localparam int HEADER_OCTETS = 20;
  localparam logic [2:0] HDR_VERSION = 3'h0;
  localparam logic [7:0] MSG_TYPE_VALUE = 8'hff;
  localparam logic [7:0] FILL_ZERO = 8'h00;
  localparam logic [7:0] FILL_ONES = 8'hff;
  localparam logic [15:0] SEQ_RESET = 16'h0000;
  localparam int LEN_HI_OCTET = 2;
  localparam int LEN_LO_OCTET = 3;
  localparam int SEQ_HI_OCTET = 4;
  localparam int SEQ_LO_OCTET = 5;
  localparam int ZERO_FIRST = 6;
  localparam int ZERO_LAST = 7;
  localparam int ONES_FIRST = 8;
  localparam int ONES_LAST = 11;
  localparam int CORR_FIRST = 12;
  localparam logic [4:0] INDEX_RESET = 5'h00;

  typedef enum logic [1:0] {
    TRANSPORT_UDP = 2'b00,
    TRANSPORT_TCP = 2'b01
  } transport_e;

  typedef struct packed {
    logic uplink;
    logic serving_node;
    logic [15:0] payload_length;
    logic [31:0] gateway_node_identifier;
    logic [31:0] context_charge_identifier;
  } packet_info_s;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } octet_s;

endpackage

/* File: hw/intercept_corr_header_framer.sv */
// Framer that prepends a 20-octet correlation header to each copied intercepted packet.
// Assumes the upstream copy logic presents one whole packet per info word and a TCP/UDP
// stack downstream that accepts a framed octet stream with valid/ready.
//
// Function
// - Prepend header to copied packet, forward it.
// - Output goes to UDP or TCP stack.
// - Version bits of octet 1 are zero.
// - Direction bit: one uplink, zero downlink.
// - Message type octet is always 255.
// - Octets 3-4 big-endian payload length.
// - Octets 5-6 increasing big-endian sequence number.
// - Octets 7-8 zero, octets 9-12 255.
// - Octets 13-20 gateway id and charge id.
// - Node bit: zero gateway, one serving node.
// - Exactly one payload after each header.
// - No reaction to receiver failure; TCP retransmits.
`timescale 1ns/1ps

module intercept_corr_header_framer
  import corr_header_pkg::*;
#(
  parameter int OCTET_WIDTH = 8
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Transport selection for the downstream stack.
  input wire transport_e transport_select,
  output transport_e transport_active,
  // Packet description, one per copied packet.
  input wire packet_info_s info_data,
  input wire logic info_valid,
  output logic info_ready,
  // Copied packet octets (original header plus payload).
  input wire octet_s in_octet,
  input wire logic in_valid,
  output logic in_ready,
  // Framed output stream.
  output octet_s out_octet,
  output logic out_valid,
  input wire logic out_ready,
  // Status.
  output logic [15:0] sequence_number,
  output logic busy
);

  initial begin
    if (OCTET_WIDTH != 8) begin
      $error("Octet width must be 8.");
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  typedef enum logic [1:0] {
    IDLE = 2'b00,
    HEADER = 2'b01,
    PAYLOAD = 2'b10
  } state_e;

  state_e state_reg, state_next;
  logic [4:0] index_reg, index_next;
  logic [15:0] seq_reg, seq_next;
  packet_info_s info_reg, info_next;
  octet_s out_reg, out_next;
  logic valid_reg, valid_next;
  transport_e transport_reg, transport_next;

  // Header octet for a given position.
  function automatic logic [7:0] header_octet(input logic [4:0] idx, input packet_info_s inf,
                                              input logic [15:0] seq);
    logic [63:0] corr;
    logic [7:0] res;
    corr = {inf.gateway_node_identifier, inf.context_charge_identifier};
    res = FILL_ZERO;
    if (idx == 5'h00) begin
      res = {HDR_VERSION, 1'b1, 1'b1, inf.serving_node, inf.uplink, 1'b0};
    end else if (idx == 5'h01) begin
      res = MSG_TYPE_VALUE;
    end else if (idx == 5'(LEN_HI_OCTET)) begin
      res = inf.payload_length[15:8];
    end else if (idx == 5'(LEN_LO_OCTET)) begin
      res = inf.payload_length[7:0];
    end else if (idx == 5'(SEQ_HI_OCTET)) begin
      res = seq[15:8];
    end else if (idx == 5'(SEQ_LO_OCTET)) begin
      res = seq[7:0];
    end else if (idx >= 5'(ZERO_FIRST) && idx <= 5'(ZERO_LAST)) begin
      res = FILL_ZERO;
    end else if (idx >= 5'(ONES_FIRST) && idx <= 5'(ONES_LAST)) begin
      res = FILL_ONES;
    end else begin
      res = corr[8'(63 - 8 * (32'(idx) - CORR_FIRST)) -: 8];
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  logic slot_free;
  assign slot_free = !valid_reg || out_ready;
  assign info_ready = (state_reg == IDLE);
  assign in_ready = (state_reg == PAYLOAD) && slot_free;

  always_comb begin
    state_next = state_reg;
    index_next = index_reg;
    seq_next = seq_reg;
    info_next = info_reg;
    out_next = out_reg;
    valid_next = valid_reg && !out_ready;
    transport_next = transport_reg;
    unique case (state_reg)
      IDLE: begin
        if (info_valid) begin
          info_next = info_data;
          transport_next = transport_select;
          index_next = INDEX_RESET;
          state_next = HEADER;
        end
      end
      HEADER: begin
        if (slot_free) begin
          out_next.data = header_octet(index_reg, info_reg, seq_reg);
          out_next.last = 1'b0;
          valid_next = 1'b1;
          if (index_reg == 5'(HEADER_OCTETS - 1)) begin
            state_next = PAYLOAD;
          end else begin
            index_next = index_reg + 5'h01;
          end
        end
      end
      PAYLOAD: begin
        if (slot_free && in_valid) begin
          out_next = in_octet;
          valid_next = 1'b1;
          if (in_octet.last) begin
            seq_next = seq_reg + 16'h0001;
            state_next = IDLE;
          end
        end
      end
      default: begin
        state_next = IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= IDLE;
      index_reg <= INDEX_RESET;
      seq_reg <= SEQ_RESET;
      info_reg <= '0;
      out_reg <= '0;
      valid_reg <= 1'b0;
      transport_reg <= TRANSPORT_UDP;
    end else begin
      state_reg <= state_next;
      index_reg <= index_next;
      seq_reg <= seq_next;
      info_reg <= info_next;
      out_reg <= out_next;
      valid_reg <= valid_next;
      transport_reg <= transport_next;
    end
  end

  assign out_octet = out_reg;
  assign out_valid = valid_reg;
  assign sequence_number = seq_reg;
  assign busy = (state_reg != IDLE);
  assign transport_active = transport_reg;

endmodule

/* File: verification/framer_monitor.sv */
// Checker for the framer ports.
// Assumes a bind onto the framer top module.
`timescale 1ns/1ps
module framer_monitor import corr_header_pkg::*; (
  // Watched ports.
  input wire logic clock,
  input wire logic reset,
  input wire logic info_valid,
  input wire logic info_ready,
  input wire octet_s in_octet,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire octet_s out_octet,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [15:0] sequence_number,
  input wire logic busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  stall_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_octet))
    else $error("stall");
  busy_info_a: assert property (busy |-> !info_ready) else $error("info");
  first_octet_a: assert property (info_valid && info_ready && (!out_valid || out_ready)
    |-> ##2 out_valid && (out_octet.data & 8'hf9) == 8'h18) else $error("flags");
  seq_step_a: assert property ($changed(sequence_number)
    |-> sequence_number - $past(sequence_number) == 16'h0001) else $error("seq");
  seq_last_a: assert property (in_valid && in_ready && in_octet.last
    |=> sequence_number - $past(sequence_number) == 16'h0001) else $error("seq last");
  last_out_a: assert property (in_valid && in_ready && in_octet.last
    |=> out_valid && out_octet.last && info_ready) else $error("last");
  in_gate_a: assert property (in_ready |-> busy && !(out_valid && !out_ready)) else $error("gate");
  busy_hold_a: assert property (info_valid && info_ready |=> busy [*8]) else $error("busy");
endmodule
bind intercept_corr_header_framer framer_monitor u_framer_monitor (.*);

/* File: verification/sink_model.sv */
// Monitoring facility model that stores framed octets.
// Assumes the framer output port names.
`timescale 1ns/1ps
module sink_model import corr_header_pkg::*; (
  // Framed stream.
  input wire logic clock,
  input wire octet_s out_octet,
  input wire logic out_valid,
  output logic out_ready
);
  logic slow = 1'b0;
  logic [8:0] got[$];
  initial out_ready = 1'b1;
  always @(posedge clock) out_ready <= !slow || !out_ready;
  always @(posedge clock) if (out_valid && out_ready) got.push_back(out_octet);
endmodule

/* File: verification/tb_intercept_corr_header_framer.sv */
// Testbench for the framer.
// Assumes package, sink model and checker compiled first.
`timescale 1ns/1ps
module tb_intercept_corr_header_framer import corr_header_pkg::*;;
  logic clock = 1'b0;
  logic reset = 1'b1;
  transport_e transport_select = TRANSPORT_UDP;
  transport_e transport_active;
  packet_info_s info_data = '0;
  logic info_valid = 1'b0;
  logic in_valid = 1'b0;
  logic info_ready, in_ready, out_valid, out_ready, busy;
  octet_s in_octet = '0;
  octet_s out_octet;
  logic [15:0] sequence_number;
  int miscompares = 0;
  int num_checks = 0;
  logic [15:0] exp_seq = 16'h0000;
  always #2.5 clock = ~clock;
  intercept_corr_header_framer u_intercept_corr_header_framer (.*);
  sink_model u_sink_model (.*);
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    num_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic run(input logic up, input logic node, input transport_e tr, input int n);
    logic [159:0] h;
    logic [15:0] seq;
    seq = exp_seq;
    info_data = {up, node, 16'(n), 32'h1234_5678, 32'h9abc_def0};
    h = {5'h03, node, up, 1'b0, 8'hff, 16'(n), seq, 16'h0000, 32'hffff_ffff, 64'h1234_5678_9abc_def0};
    transport_select = tr;
    info_valid = 1'b1;
    while (!info_ready) @(negedge clock);
    @(negedge clock);
    info_valid = 1'b0;
    for (int i = 0; i < n; i++) begin
      in_octet = {8'(8'ha0 + i), i == n - 1};
      in_valid = 1'b1;
      while (!in_ready) @(negedge clock);
      @(negedge clock);
    end
    in_valid = 1'b0;
    while (u_sink_model.got.size() < 20 + n) @(negedge clock);
    for (int k = 0; k < 20 + n; k++) begin
      if (k < 20) check(u_sink_model.got[k], {h[159 - 8 * k -: 8], 1'b0});
      else check(u_sink_model.got[k], {8'(8'ha0 + k - 20), k == 19 + n});
    end
    check(sequence_number, seq + 16'h0001);
    exp_seq = seq + 16'h0001;
    check(transport_active, tr);
    u_sink_model.got.delete();
  endtask
  task automatic t_stall();
    u_sink_model.slow = 1'b1;
    run(1'b0, 1'b1, TRANSPORT_TCP, 1);
    u_sink_model.slow = 1'b0;
  endtask
  task automatic t_reset();
    reset = 1'b1;
    repeat (12) @(negedge clock);
    reset = 1'b0;
    exp_seq = 16'h0000;
    check(sequence_number, 16'h0000);
    check(out_valid, 1'b0);
    check(busy, 1'b0);
    check(info_ready, 1'b1);
    check(transport_active, TRANSPORT_UDP);
  endtask
  task automatic end_sim();
    if (miscompares == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #5000;
    miscompares++;
    end_sim();
  end
  initial begin
    repeat (12) @(negedge clock);
    reset = 1'b0;
    run(1'b1, 1'b0, TRANSPORT_UDP, 3);
    t_stall();
    run(1'b1, 1'b1, TRANSPORT_UDP, 2);
    t_reset();
    run(1'b0, 1'b0, TRANSPORT_UDP, 1);
    end_sim();
  end
endmodule
